// file: design/psb_cfg.svh
// timing and width constants for the pci sideband ends
// assumes inclusion by bare name from the design files
`ifndef PSB_CFG_SVH
`define PSB_CFG_SVH
`define PSB_AD_W 32
`define PSB_CBE_W 4
`define PSB_PERR_LAG 2
`define PSB_PAR_LAG 1
`define PSB_CMD_CFG_RD 4'ha
`define PSB_CMD_CFG_WR 4'hb
`define PSB_CMD_MEM_RD 4'h6
`define PSB_CMD_MEM_WR 4'h7
`endif

// file: design/psb_pkg.sv
// types shared by both ends of the pci sideband link
// assumes psb_cfg.svh is on the include path
package psb_pkg;
  typedef enum logic [1:0] {
    PSB_IDLE,
    PSB_REQ,
    PSB_ADDR,
    PSB_DATA
  } psb_mst_t;
endpackage

// file: design/psb_if.sv
// interface joining the device end and the host end
// assumes one clock, sys_clk, shared by both ends
`timescale 1ns/1ps
`include "psb_cfg.svh"
interface psb_if;
  logic [31:0] ad_dev;
  logic ad_dev_oe;
  logic [31:0] ad_host;
  logic ad_host_oe;
  logic [3:0] cbe_dev;
  logic [3:0] cbe_host;
  logic par_dev;
  logic par_dev_oe;
  logic par_host;
  logic par_host_oe;
  logic frame_n_dev;
  logic frame_dev_oe;
  logic frame_n_host;
  logic frame_host_oe;
  logic devsel_n_o;
  logic devsel_oe;
  logic idsel;
  logic serr_n_o;
  logic serr_oe;
  logic perr_n_dev;
  logic perr_dev_oe;
  logic perr_n_host;
  logic perr_host_oe;
  logic inta_n_o;
  logic inta_oe;
  logic intb_n_o;
  logic intb_oe;
  logic req_n;
  logic gnt_n;
  logic m66en;
  modport dev (
    output ad_dev, ad_dev_oe, cbe_dev, par_dev, par_dev_oe, frame_n_dev, frame_dev_oe,
    output devsel_n_o, devsel_oe, serr_n_o, serr_oe, perr_n_dev, perr_dev_oe,
    output inta_n_o, inta_oe, intb_n_o, intb_oe, req_n,
    input ad_host, ad_host_oe, cbe_host, par_host, par_host_oe, frame_n_host,
    input frame_host_oe, idsel, perr_n_host, perr_host_oe, gnt_n, m66en
  );
  modport host (
    input ad_dev, ad_dev_oe, cbe_dev, par_dev, par_dev_oe, frame_n_dev, frame_dev_oe,
    input devsel_n_o, devsel_oe, serr_n_o, serr_oe, perr_n_dev, perr_dev_oe,
    input inta_n_o, inta_oe, intb_n_o, intb_oe, req_n,
    output ad_host, ad_host_oe, cbe_host, par_host, par_host_oe, frame_n_host,
    output frame_host_oe, idsel, perr_n_host, perr_host_oe, gnt_n, m66en
  );
endinterface

// file: design/psb_dev.sv
// device end: target select, parity errors, interrupts, bus request
// assumes the host end drives the host modport; one clock, sync reset
// Behaviour
// - assert device select on own address decode
// - configuration cycles answered only with idsel
// - system error open drain, pulled low only
// - system error never read back
// - receiver flags data parity two clocks later
// - master write parity error queues descriptor
// - master read parity error queues descriptor
// - first interrupt low while channel event pending
// - second interrupt low while expansion event pending
// - request asserted when mastering wanted
// - frame started only while granted
// - system sets m66en for 66 MHz clock
// - parity makes ones count even
// - parity lags covered data one clock
`timescale 1ns/1ps
`include "psb_cfg.svh"
module psb_dev
  import psb_pkg::*;
#(
  parameter logic [31:0] BAR_BASE = 32'h1000_0000,
  parameter int BAR_BITS = 12
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  psb_if.dev bus,
  input wire logic l2_irq_pending,
  input wire logic lxb_irq_pending,
  input wire logic mst_start,
  input wire logic mst_write,
  input wire logic [31:0] mst_addr,
  input wire logic [31:0] mst_wdata,
  output logic mst_done,
  output logic [31:0] mst_rdata,
  output logic perr_desc_valid,
  output logic perr_desc_write,
  output logic cfg_hit,
  output logic mem_hit,
  output logic fast_clk
);
  if (BAR_BITS < 4 || BAR_BITS > 31) begin : g_bad_bits
    $error("BAR_BITS out of range");
  end

  // ----------------------------------------------------------------
  // target decode, address parity, interrupt levels
  // ----------------------------------------------------------------
  logic frame_d_r, frame_d_nxt, addr_chk_r, addr_chk_nxt;
  logic [31:0] ad_d_r, ad_d_nxt;
  logic [3:0] cbe_d_r, cbe_d_nxt;
  logic devsel_r, devsel_nxt, serr_r, serr_nxt, fast_r, fast_nxt;
  logic cfg_hit_r, cfg_hit_nxt, mem_hit_r, mem_hit_nxt;
  logic inta_r, inta_nxt, intb_r, intb_nxt;
  logic addr_phase, bar_match, is_cfg, is_mem;

  always_comb begin
    addr_phase = bus.frame_host_oe && !bus.frame_n_host && frame_d_r;
    bar_match = (bus.ad_host[31:BAR_BITS] == BAR_BASE[31:BAR_BITS]);
    is_cfg = (bus.cbe_host == `PSB_CMD_CFG_RD) || (bus.cbe_host == `PSB_CMD_CFG_WR);
    is_mem = (bus.cbe_host == `PSB_CMD_MEM_RD) || (bus.cbe_host == `PSB_CMD_MEM_WR);
    frame_d_nxt = !(bus.frame_host_oe && !bus.frame_n_host);
    addr_chk_nxt = addr_phase;
    ad_d_nxt = bus.ad_host;
    cbe_d_nxt = bus.cbe_host;
    cfg_hit_nxt = addr_phase && is_cfg && bus.idsel;
    mem_hit_nxt = addr_phase && is_mem && bar_match;
    devsel_nxt = devsel_r;
    if (addr_phase) begin
      devsel_nxt = (is_cfg && bus.idsel) || (is_mem && bar_match);
    end else if (bus.frame_n_host || !bus.frame_host_oe) begin
      devsel_nxt = 1'b0;
    end
    // even parity over ad, cbe and par, one clock behind the address
    serr_nxt = addr_chk_r && bus.par_host_oe
      && (^{ad_d_r, cbe_d_r, bus.par_host});
    fast_nxt = bus.m66en;
    inta_nxt = l2_irq_pending;
    intb_nxt = lxb_irq_pending;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      frame_d_r <= 1'b1;
      addr_chk_r <= 1'b0;
      ad_d_r <= 32'h0000_0000;
      cbe_d_r <= 4'h0;
      devsel_r <= 1'b0;
      serr_r <= 1'b0;
      cfg_hit_r <= 1'b0;
      mem_hit_r <= 1'b0;
      fast_r <= 1'b0;
      inta_r <= 1'b0;
      intb_r <= 1'b0;
    end else begin
      frame_d_r <= frame_d_nxt;
      addr_chk_r <= addr_chk_nxt;
      ad_d_r <= ad_d_nxt;
      cbe_d_r <= cbe_d_nxt;
      devsel_r <= devsel_nxt;
      serr_r <= serr_nxt;
      cfg_hit_r <= cfg_hit_nxt;
      mem_hit_r <= mem_hit_nxt;
      fast_r <= fast_nxt;
      inta_r <= inta_nxt;
      intb_r <= intb_nxt;
    end
  end

  // ----------------------------------------------------------------
  // master sequencer with request, grant and data parity
  // ----------------------------------------------------------------
  psb_mst_t st_r, st_nxt;
  logic req_r, req_nxt, wr_r, wr_nxt, frame_r, frame_nxt, done_r, done_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [31:0] ad_o_r, ad_o_nxt;
  logic [3:0] cbe_o_r, cbe_o_nxt;
  logic ad_oe_r, ad_oe_nxt, par_r, par_nxt, par_oe_r, par_oe_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [2:0] dph_r, dph_nxt;
  logic rchk_r, rchk_nxt, perr_o_r, perr_o_nxt, desc_v_r, desc_v_nxt, desc_w_r, desc_w_nxt;

  always_comb begin
    st_nxt = st_r;
    req_nxt = req_r;
    wr_nxt = wr_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    ad_o_nxt = ad_o_r;
    cbe_o_nxt = cbe_o_r;
    ad_oe_nxt = 1'b0;
    frame_nxt = 1'b0;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    rchk_nxt = 1'b0;
    dph_nxt = {dph_r[1:0], 1'b0};
    // parity follows whatever was driven one clock earlier
    par_nxt = ^{ad_o_r, cbe_o_r};
    par_oe_nxt = ad_oe_r;
    desc_v_nxt = 1'b0;
    desc_w_nxt = desc_w_r;
    // receiver checks read data: flag one clock after par arrives
    perr_o_nxt = rchk_r && bus.par_host_oe && (^{rdata_r, cbe_o_r, bus.par_host});
    unique case (st_r)
      PSB_IDLE: begin
        if (mst_start) begin
          st_nxt = PSB_REQ;
          req_nxt = 1'b1;
          wr_nxt = mst_write;
          addr_nxt = mst_addr;
          wdata_nxt = mst_wdata;
        end
      end
      PSB_REQ: begin
        if (!bus.gnt_n && bus.frame_n_host && !devsel_r) begin
          st_nxt = PSB_ADDR;
          frame_nxt = 1'b1;
          ad_oe_nxt = 1'b1;
          ad_o_nxt = addr_r;
          cbe_o_nxt = wr_r ? `PSB_CMD_MEM_WR : `PSB_CMD_MEM_RD;
        end
      end
      PSB_ADDR: begin
        st_nxt = PSB_DATA;
        req_nxt = 1'b0;
        ad_oe_nxt = wr_r;
        ad_o_nxt = wr_r ? wdata_r : ad_o_r;
        cbe_o_nxt = 4'h0;
        dph_nxt = {dph_r[1:0], wr_r};
      end
      PSB_DATA: begin
        st_nxt = PSB_IDLE;
        done_nxt = 1'b1;
        if (!wr_r) begin
          rdata_nxt = bus.ad_host;
          rchk_nxt = bus.ad_host_oe;
        end
      end
    endcase
    // write data driven in data phase; target perr two clocks later
    if (dph_r[2] && bus.perr_host_oe && !bus.perr_n_host) begin
      desc_v_nxt = 1'b1;
      desc_w_nxt = 1'b1;
    end else if (perr_o_nxt) begin
      desc_v_nxt = 1'b1;
      desc_w_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= PSB_IDLE;
      req_r <= 1'b0;
      wr_r <= 1'b0;
      addr_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      ad_o_r <= 32'h0000_0000;
      cbe_o_r <= 4'h0;
      ad_oe_r <= 1'b0;
      par_r <= 1'b0;
      par_oe_r <= 1'b0;
      frame_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      dph_r <= 3'h0;
      rchk_r <= 1'b0;
      perr_o_r <= 1'b0;
      desc_v_r <= 1'b0;
      desc_w_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      req_r <= req_nxt;
      wr_r <= wr_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      ad_o_r <= ad_o_nxt;
      cbe_o_r <= cbe_o_nxt;
      ad_oe_r <= ad_oe_nxt;
      par_r <= par_nxt;
      par_oe_r <= par_oe_nxt;
      frame_r <= frame_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      dph_r <= dph_nxt;
      rchk_r <= rchk_nxt;
      perr_o_r <= perr_o_nxt;
      desc_v_r <= desc_v_nxt;
      desc_w_r <= desc_w_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pin mapping; open-drain pins drive only a low level
  // ----------------------------------------------------------------
  assign bus.ad_dev = ad_o_r;
  assign bus.ad_dev_oe = ad_oe_r;
  assign bus.cbe_dev = cbe_o_r;
  assign bus.par_dev = par_r;
  assign bus.par_dev_oe = par_oe_r;
  assign bus.frame_n_dev = !frame_r;
  assign bus.frame_dev_oe = frame_r;
  assign bus.devsel_n_o = !devsel_r;
  assign bus.devsel_oe = devsel_r;
  assign bus.serr_n_o = 1'b0;
  assign bus.serr_oe = serr_r;
  assign bus.perr_n_dev = !perr_o_r;
  assign bus.perr_dev_oe = perr_o_r;
  assign bus.inta_n_o = 1'b0;
  assign bus.inta_oe = inta_r;
  assign bus.intb_n_o = 1'b0;
  assign bus.intb_oe = intb_r;
  assign bus.req_n = !req_r;
  assign mst_done = done_r;
  assign mst_rdata = rdata_r;
  assign perr_desc_valid = desc_v_r;
  assign perr_desc_write = desc_w_r;
  assign cfg_hit = cfg_hit_r;
  assign mem_hit = mem_hit_r;
  assign fast_clk = fast_r;
endmodule

// file: design/psb_host.sv
// host end: arbiter, idsel, m66en, single-cycle master and data target
// assumes the device end drives the dev modport; one clock, sync reset
`timescale 1ns/1ps
`include "psb_cfg.svh"
module psb_host
  import psb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  psb_if.host bus,
  input wire logic clk_is_66,
  input wire logic arb_allow,
  input wire logic cyc_start,
  input wire logic cyc_cfg,
  input wire logic [3:0] cyc_cmd,
  input wire logic [31:0] cyc_addr,
  input wire logic [31:0] tgt_rdata,
  input wire logic bad_par,
  output logic cyc_claimed,
  output logic serr_seen,
  output logic perr_seen,
  output logic inta_level,
  output logic intb_level,
  output logic dev_req
);
  // ----------------------------------------------------------------
  // master cycles, arbiter and target answer
  // ----------------------------------------------------------------
  logic [2:0] ph_r, ph_nxt;
  logic frame_r, frame_nxt;
  logic [31:0] ad_r, ad_nxt;
  logic ad_oe_r, ad_oe_nxt;
  logic [3:0] cbe_r, cbe_nxt;
  logic par_r, par_nxt;
  logic par_oe_r, par_oe_nxt;
  logic idsel_r, idsel_nxt;
  logic gnt_r, gnt_nxt;
  logic m66_r, m66_nxt;
  logic claim_r, claim_nxt;
  logic wchk_r, wchk_nxt;
  logic wchk2_r, wchk2_nxt;
  logic [35:0] wd_r, wd_nxt;
  logic perr_r, perr_nxt;
  logic serr_r, serr_nxt;
  logic perr_s_r, perr_s_nxt;
  logic inta_r, inta_nxt;
  logic intb_r, intb_nxt;
  logic req_r, req_nxt;
  logic dev_addr;
  logic dev_wr;

  always_comb begin
    dev_addr = bus.frame_dev_oe && !bus.frame_n_dev;
    dev_wr = bus.cbe_dev == `PSB_CMD_MEM_WR;
    ph_nxt = {ph_r[1:0], 1'b0};
    frame_nxt = 1'b0;
    ad_nxt = ad_r;
    ad_oe_nxt = 1'b0;
    cbe_nxt = cbe_r;
    idsel_nxt = 1'b0;
    claim_nxt = claim_r | (bus.devsel_oe && !bus.devsel_n_o);
    // parity one clock after ad/cbe, optionally corrupted
    par_nxt = (^{ad_r, cbe_r}) ^ bad_par;
    par_oe_nxt = ad_oe_r;
    if (cyc_start && ph_r == 3'h0 && bus.req_n) begin
      ph_nxt = 3'h1;
      frame_nxt = 1'b1;
      ad_oe_nxt = 1'b1;
      ad_nxt = cyc_addr;
      cbe_nxt = cyc_cmd;
      idsel_nxt = cyc_cfg;
      claim_nxt = 1'b0;
    end
    if (dev_addr && !dev_wr) begin
      ad_oe_nxt = 1'b1;
      ad_nxt = tgt_rdata;
      cbe_nxt = 4'h0;
    end
    // grant only while the device requests and host is idle
    gnt_nxt = !bus.req_n && arb_allow && ph_r == 3'h0 && !frame_r;
    m66_nxt = clk_is_66;
    // host is receiver for device write data: check two clocks on
    wchk_nxt = dev_addr && dev_wr;
    wchk2_nxt = wchk_r && bus.ad_dev_oe;
    wd_nxt = {bus.ad_dev, bus.cbe_dev};
    perr_nxt = wchk2_r && (bad_par || (bus.par_dev_oe && (^{wd_r, bus.par_dev})));
    serr_nxt = bus.serr_oe && !bus.serr_n_o;
    perr_s_nxt = bus.perr_dev_oe && !bus.perr_n_dev;
    inta_nxt = bus.inta_oe && !bus.inta_n_o;
    intb_nxt = bus.intb_oe && !bus.intb_n_o;
    req_nxt = !bus.req_n;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ph_r <= 3'h0;
      frame_r <= 1'b0;
      ad_r <= 32'h0000_0000;
      ad_oe_r <= 1'b0;
      cbe_r <= 4'h0;
      par_r <= 1'b0;
      par_oe_r <= 1'b0;
      idsel_r <= 1'b0;
      gnt_r <= 1'b0;
      m66_r <= 1'b0;
      claim_r <= 1'b0;
      wchk_r <= 1'b0;
      wchk2_r <= 1'b0;
      wd_r <= 36'h0;
      perr_r <= 1'b0;
      serr_r <= 1'b0;
      perr_s_r <= 1'b0;
      inta_r <= 1'b0;
      intb_r <= 1'b0;
      req_r <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
      frame_r <= frame_nxt;
      ad_r <= ad_nxt;
      ad_oe_r <= ad_oe_nxt;
      cbe_r <= cbe_nxt;
      par_r <= par_nxt;
      par_oe_r <= par_oe_nxt;
      idsel_r <= idsel_nxt;
      gnt_r <= gnt_nxt;
      m66_r <= m66_nxt;
      claim_r <= claim_nxt;
      wchk_r <= wchk_nxt;
      wchk2_r <= wchk2_nxt;
      wd_r <= wd_nxt;
      perr_r <= perr_nxt;
      serr_r <= serr_nxt;
      perr_s_r <= perr_s_nxt;
      inta_r <= inta_nxt;
      intb_r <= intb_nxt;
      req_r <= req_nxt;
    end
  end

  assign bus.ad_host = ad_r;
  assign bus.ad_host_oe = ad_oe_r;
  assign bus.cbe_host = cbe_r;
  assign bus.par_host = par_r;
  assign bus.par_host_oe = par_oe_r;
  assign bus.frame_n_host = !frame_r;
  assign bus.frame_host_oe = frame_r;
  assign bus.idsel = idsel_r;
  assign bus.perr_n_host = !perr_r;
  assign bus.perr_host_oe = perr_r;
  assign bus.gnt_n = !gnt_r;
  assign bus.m66en = m66_r;
  assign cyc_claimed = claim_r;
  assign serr_seen = serr_r;
  assign perr_seen = perr_s_r;
  assign inta_level = inta_r;
  assign intb_level = intb_r;
  assign dev_req = req_r;
endmodule

// file: tb/psb_sb_monitor.sv
// concurrent checks on the wires between the two sideband ends
// assumes one instance beside the interface in the bench top
`timescale 1ns/1ps
`include "psb_cfg.svh"
module psb_sb_monitor (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic frame_dev_oe,
  input wire logic frame_host_oe,
  input wire logic devsel_oe,
  input wire logic idsel,
  input wire logic [3:0] cbe_host,
  input wire logic [31:0] ad_host,
  input wire logic ad_host_oe,
  input wire logic par_host,
  input wire logic par_host_oe,
  input wire logic serr_oe,
  input wire logic serr_n_o,
  input wire logic inta_oe,
  input wire logic inta_n_o,
  input wire logic intb_oe,
  input wire logic intb_n_o,
  input wire logic req_n,
  input wire logic gnt_n,
  input wire logic perr_dev_oe,
  input wire logic perr_host_oe
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic fr_r;
  logic hph_r;
  logic [35:0] adc_r;
  logic frame_on;
  logic hphase;
  logic cfg_cmd;
  logic pbad;
  assign frame_on = frame_dev_oe | frame_host_oe;
  assign hphase = frame_host_oe & ~fr_r;
  assign cfg_cmd = (cbe_host == `PSB_CMD_CFG_RD) || (cbe_host == `PSB_CMD_CFG_WR);
  // parity of the address phase, one clock late
  assign pbad = hph_r & (par_host != ^adc_r);
  always_ff @(posedge sys_clk) begin
    fr_r <= frame_on;
    hph_r <= hphase;
    adc_r <= {ad_host, cbe_host};
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_cfg_sel;
    hphase && cfg_cmd && idsel;
  endsequence
  sequence s_bad_addr;
    hphase ##1 pbad;
  endsequence
  a_cfg_claim: assert property (s_cfg_sel |=> devsel_oe)
    else $error("config cycle with idsel not claimed");
  a_cfg_needs_idsel: assert property (hphase && cfg_cmd && !idsel |=> !devsel_oe)
    else $error("config cycle claimed without idsel");
  a_devsel_drop: assert property (devsel_oe && !frame_on |=> !devsel_oe)
    else $error("device select held after frame gone");
  a_serr_addr_only: assert property (serr_oe |-> $past(pbad))
    else $error("system error without address parity fault");
  a_serr_on_bad: assert property (s_bad_addr |=> serr_oe ##1 !serr_oe)
    else $error("address parity fault not flagged for one cycle");
  a_od_low_only: assert property ((serr_oe | inta_oe | intb_oe) |-> !(serr_n_o | inta_n_o | intb_n_o))
    else $error("open drain pin driven high");
  a_frame_granted: assert property ($rose(frame_dev_oe) |-> $past(gnt_n) == 1'b0 ##1 !frame_dev_oe)
    else $error("frame started without grant or held too long");
  a_req_first: assert property ($rose(frame_dev_oe) |-> $past(req_n) == 1'b0)
    else $error("frame started without request");
  a_perr_lag: assert property (perr_dev_oe |-> $past(par_host_oe) && $past(ad_host_oe, 2))
    else $error("device parity error at wrong lag");
  a_perr_host_lag: assert property (perr_host_oe |-> $past(frame_dev_oe, 3))
    else $error("host parity error at wrong lag");
endmodule

// file: tb/test_pci_target_master_sideband.sv
// self-checking bench joining the device end and the host end
// assumes design files and psb_cfg.svh on the include path
`timescale 1ns/1ps
`include "psb_cfg.svh"
module test_pci_target_master_sideband
  import psb_pkg::*;
;
  localparam logic [31:0] BAR = 32'h1000_0000;
  localparam int BB = 12;
  logic sys_clk, sys_rst, l2_irq_pending, lxb_irq_pending, mst_start, mst_write;
  logic [31:0] mst_addr, mst_wdata, mst_rdata, cyc_addr, tgt_rdata, a;
  logic mst_done, perr_desc_valid, perr_desc_write, cfg_hit, mem_hit, fast_clk;
  logic clk_is_66, arb_allow, cyc_start, cyc_cfg, bad_par, v0, v1;
  logic [3:0] cyc_cmd;
  logic cyc_claimed, serr_seen, perr_seen, inta_level, intb_level, dev_req;
  logic [3:0] cmds [7] = '{4'ha, 4'hb, 4'h6, 4'h7, 4'h0, 4'h1, 4'hc};
  int fail_count, checked, n_cfg, n_mem, n_serr, n_sseen, n_perr, n_hperr;
  logic desc_q[$];
  psb_if psb_if_i ();
  psb_dev #(.BAR_BASE(BAR), .BAR_BITS(BB)) psb_dev_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .bus(psb_if_i.dev), .l2_irq_pending(l2_irq_pending), .lxb_irq_pending(lxb_irq_pending),
    .mst_start(mst_start), .mst_write(mst_write), .mst_addr(mst_addr), .mst_wdata(mst_wdata),
    .mst_done(mst_done), .mst_rdata(mst_rdata), .perr_desc_valid(perr_desc_valid),
    .perr_desc_write(perr_desc_write), .cfg_hit(cfg_hit), .mem_hit(mem_hit), .fast_clk(fast_clk));
  psb_host psb_host_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(psb_if_i.host),
    .clk_is_66(clk_is_66), .arb_allow(arb_allow), .cyc_start(cyc_start), .cyc_cfg(cyc_cfg),
    .cyc_cmd(cyc_cmd), .cyc_addr(cyc_addr), .tgt_rdata(tgt_rdata), .bad_par(bad_par),
    .cyc_claimed(cyc_claimed), .serr_seen(serr_seen), .perr_seen(perr_seen),
    .inta_level(inta_level), .intb_level(intb_level), .dev_req(dev_req));
  psb_sb_monitor psb_sb_monitor_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .frame_dev_oe(psb_if_i.frame_dev_oe), .frame_host_oe(psb_if_i.frame_host_oe),
    .devsel_oe(psb_if_i.devsel_oe), .idsel(psb_if_i.idsel), .cbe_host(psb_if_i.cbe_host),
    .ad_host(psb_if_i.ad_host), .ad_host_oe(psb_if_i.ad_host_oe), .par_host(psb_if_i.par_host),
    .par_host_oe(psb_if_i.par_host_oe), .serr_oe(psb_if_i.serr_oe),
    .serr_n_o(psb_if_i.serr_n_o), .inta_oe(psb_if_i.inta_oe), .inta_n_o(psb_if_i.inta_n_o),
    .intb_oe(psb_if_i.intb_oe), .intb_n_o(psb_if_i.intb_n_o), .req_n(psb_if_i.req_n),
    .gnt_n(psb_if_i.gnt_n), .perr_dev_oe(psb_if_i.perr_dev_oe),
    .perr_host_oe(psb_if_i.perr_host_oe));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("checks=%0d errors=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task host_cyc(input logic cfg, input logic [3:0] cmd, input logic [31:0] ad, input logic bp);
    int c0, m0, s0, q0;
    logic ec, em;
    c0 = n_cfg;
    m0 = n_mem;
    s0 = n_serr;
    q0 = n_sseen;
    ec = (cmd == `PSB_CMD_CFG_RD || cmd == `PSB_CMD_CFG_WR) && cfg;
    em = (cmd == `PSB_CMD_MEM_RD || cmd == `PSB_CMD_MEM_WR) && ad[31:BB] == BAR[31:BB];
    cyc_start = 1;
    cyc_cfg = cfg;
    cyc_cmd = cmd;
    cyc_addr = ad;
    bad_par = bp;
    @(negedge sys_clk);
    cyc_start = 0;
    repeat (8) @(negedge sys_clk);
    bad_par = 0;
    chk(n_cfg - c0, ec);
    chk(n_mem - m0, em);
    chk(cyc_claimed, ec | em);
    chk(n_serr - s0, bp);
    chk(n_sseen - q0, bp);
  endtask
  task dev_op(input logic wr, input logic [31:0] ad, input logic [31:0] d, input logic bp);
    int k, p0, h0;
    p0 = n_perr;
    h0 = n_hperr;
    tgt_rdata = d;
    bad_par = bp;
    if (bp) desc_q.push_back(wr);
    mst_start = 1;
    mst_write = wr;
    mst_addr = ad;
    mst_wdata = d;
    @(negedge sys_clk);
    mst_start = 0;
    repeat (2 + $urandom % 5) @(negedge sys_clk);
    chk(dev_req, 1);
    chk(psb_if_i.frame_dev_oe, 0);
    arb_allow = 1;
    k = 0;
    while (mst_done !== 1'b1 && k < 40) begin
      @(negedge sys_clk);
      k++;
    end
    chk(k < 40, 1);
    if (!wr) chk(mst_rdata, d);
    repeat (5) @(negedge sys_clk);
    chk(n_hperr - h0, bp & wr);
    chk(n_perr - p0, bp & !wr);
    arb_allow = 0;
    bad_par = 0;
  endtask
  // ----------------------------------------
  // observers, clock, watchdog
  // ----------------------------------------
  always @(negedge sys_clk) begin
    if (!sys_rst) begin
      n_cfg += (cfg_hit === 1'b1);
      n_mem += (mem_hit === 1'b1);
      n_serr += (psb_if_i.serr_oe === 1'b1);
      n_sseen += (serr_seen === 1'b1);
      n_perr += (perr_seen === 1'b1);
      n_hperr += (psb_if_i.perr_host_oe === 1'b1);
      if (perr_desc_valid === 1'b1) begin
        if (desc_q.size() == 0) chk(perr_desc_valid, 0);
        else chk(perr_desc_write, desc_q.pop_front());
      end
    end
  end
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    fail_count++;
    print_verdict;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {sys_rst, l2_irq_pending, lxb_irq_pending, mst_start, mst_write} = 5'h10;
    {clk_is_66, arb_allow, cyc_start, cyc_cfg, bad_par} = 5'h00;
    {mst_addr, mst_wdata, cyc_addr, tgt_rdata, cyc_cmd} = '0;
    void'($urandom(32'h80aa));
    repeat (20) @(negedge sys_clk);
    sys_rst = 0;
    chk(psb_if_i.req_n, 1);
    chk({inta_level, intb_level, dev_req}, 0);
    for (int i = 0; i < 14; i++) begin
      a = $urandom;
      a[31:BB] = (i % 4 < 2) ? BAR[31:BB] : ~BAR[31:BB];
      host_cyc(i[0], cmds[i / 2], a, 1'b0);
    end
    host_cyc(1'b0, `PSB_CMD_CFG_RD, $urandom, 1'b1);
    host_cyc(1'b0, `PSB_CMD_MEM_WR, ~BAR, 1'b1);
    for (int i = 0; i < 8; i++) begin
      dev_op(i[0], $urandom, $urandom, i[1]);
    end
    for (int i = 0; i < 8; i++) begin
      {v0, v1} = 2'($urandom);
      l2_irq_pending = v0;
      lxb_irq_pending = v1;
      clk_is_66 = v0 ^ v1;
      repeat (4) @(negedge sys_clk);
      chk(inta_level, v0);
      chk(intb_level, v1);
      chk(fast_clk, v0 ^ v1);
    end
    chk(desc_q.size(), 0);
    print_verdict;
  end
endmodule
